// [pkg/dlps_regs.svh]
// register map, field layout and constants of the pattern/format selector
// ****************************************************************************
// What this block does
// - thirteen 1080-line output formats offered
// - resync framing when active format changes
// - high-rate progressive forces 4:2:2 10-bit
// - request integer or 1.001 clock per format
// - clock switches with no confirmation prompt
// - selector picks set, repeats cycle patterns
// - color bars: 100%, 75%, HD/SD compatible
// - linearity: five-step staircase, ramp, valid ramp
// - flat fields: eleven levels in 10% steps
// - monitor: RGB at 100%/75% plus convergence
// - dedicated selector enters converter mode
// - converter flags missing or mismatched input
// ****************************************************************************
`ifndef DLPS_REGS_SVH
`define DLPS_REGS_SVH

// register byte offsets
`define DLPS_CMD_OFS      12'h000
`define DLPS_CAND_OFS     12'h004
`define DLPS_STAT_OFS     12'h008
`define DLPS_IRQ_STAT_OFS 12'h00c
`define DLPS_IRQ_CLR_OFS  12'h010
`define DLPS_IRQ_EN_OFS   12'h014
`define DLPS_SAMP_OFS     12'h018

// command register fields
`define DLPS_CMD_CODE_LSB 0
`define DLPS_CMD_CODE_MSB 3

// status register field positions
`define DLPS_ST_FMT_LSB   0
`define DLPS_ST_FMT_MSB   3
`define DLPS_ST_SET_LSB   4
`define DLPS_ST_SET_MSB   6
`define DLPS_ST_PAT_LSB   8
`define DLPS_ST_PAT_MSB   11
`define DLPS_ST_CONV_BIT  12
`define DLPS_ST_FRAC_BIT  13
`define DLPS_ST_ERR_BIT   14
`define DLPS_ST_SAMP_LSB  16
`define DLPS_ST_SAMP_MSB  19

// interrupt bit positions
`define DLPS_IRQ_FMT_BIT  0
`define DLPS_IRQ_CLK_BIT  1
`define DLPS_IRQ_ERR_BIT  2
`define DLPS_IRQ_W        3

// pattern counts per set and number of output formats
`define DLPS_N_BARS       4'h3
`define DLPS_N_LIN        4'h3
`define DLPS_N_FLAT       4'hb
`define DLPS_N_MON        4'h7
`define DLPS_N_PULSE      4'h1
`define DLPS_N_FMT        4'hd

// reset values, 4:2:2 10-bit sampling code and field widths
`define DLPS_FMT_RST      4'h8
`define DLPS_SAMP_RST     4'h0
`define DLPS_SAMP_422_10  4'h7
`define DLPS_CMD_W        4
`define DLPS_SAMP_W       4

`endif

// [pkg/dlps_pkg.sv]
// types shared by the pattern/format selector
package dlps_pkg;

	// output formats, in front-panel order
	typedef enum logic [3:0] {
		FMT_2398SF = 4'h0, FMT_24SF = 4'h1, FMT_2398P = 4'h2,
		FMT_24P = 4'h3, FMT_25P = 4'h4, FMT_2997P = 4'h5,
		FMT_30P = 4'h6, FMT_50I = 4'h7, FMT_5994I = 4'h8,
		FMT_60I = 4'h9, FMT_50P = 4'ha, FMT_5994P = 4'hb,
		FMT_60P = 4'hc
	} dlps_fmt_type;

	// pattern sets
	typedef enum logic [2:0] {
		SET_BARS = 3'h0, SET_LIN = 3'h1, SET_FLAT = 3'h2,
		SET_MON = 3'h3, SET_PULSE = 3'h4
	} dlps_set_type;

	// front-panel / remote command codes
	typedef enum logic [3:0] {
		CMD_NONE = 4'h0, CMD_FORMAT = 4'h1, CMD_LEFT = 4'h2,
		CMD_RIGHT = 4'h3, CMD_ENTER = 4'h4, CMD_CANCEL = 4'h5,
		CMD_BARS = 4'h6, CMD_LIN = 4'h7, CMD_FLAT = 4'h8,
		CMD_MON = 4'h9, CMD_PULSE = 4'ha, CMD_OTHER = 4'hb,
		CMD_MBURST = 4'hc, CMD_SWEEP = 4'hd, CMD_TIMING = 4'he,
		CMD_SDI = 4'hf
	} dlps_cmd_type;

	// menu focus
	typedef enum logic [1:0] {
		MENU_MAIN = 2'b00, MENU_FMT = 2'b01, MENU_SIG = 2'b10,
		MENU_CONV = 2'b11
	} dlps_menu_type;

	// selection outputs travelling together
	typedef struct packed {
		dlps_fmt_type fmt;
		dlps_set_type pset;
		logic [3:0]   pat;
		logic         conv;
		logic         y2gbr;
		logic         clk_frac;
		logic [3:0]   samp;
	} dlps_sel_type;

endpackage : dlps_pkg

// [logic/dlps_inmon.sv]
// converter input monitor: synchronises the input status and flags errors
`timescale 1ns/100ps
`include "dlps_regs.svh"
module dlps_inmon
	import dlps_pkg::*;
(
	input  wire logic         pclk,       // system clock
	input  wire logic         presetn,    // async reset, active low
	input  wire logic         ce,         // clock enable
	input  wire logic         present,    // input carrier present (pin)
	input  wire logic [3:0]   in_fmt,     // detected input format (pin)
	input  wire logic         conv,       // converter mode active
	input  dlps_fmt_type      fmt,        // selected output format
	output logic              err         // input signal error
);
	typedef struct packed {
		logic [4:0] s1;
		logic [4:0] s2;
		logic       err;
	} dlps_mon_type;

	dlps_mon_type st_r, st_nxt;

	// true when an input format feeds the chosen output (the same format; for 50P/59.94P/60P only the half-rate interlaced one)
	function automatic logic rate_ok(input logic [3:0] i, input dlps_fmt_type o);
		unique case (o)
			FMT_50P:   rate_ok = (i == FMT_50I);
			FMT_5994P: rate_ok = (i == FMT_5994I);
			FMT_60P:   rate_ok = (i == FMT_60I);
			default:   rate_ok = (i == o);
		endcase
	endfunction : rate_ok

	// two-stage synchroniser; only stage two is examined
	always_comb begin
		st_nxt     = st_r;
		st_nxt.s1  = {present, in_fmt};
		st_nxt.s2  = st_r.s1;
		st_nxt.err = conv & (~st_r.s2[4] |
			~rate_ok(st_r.s2[3:0], fmt));
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			st_r <= '0;
		else if (ce)
			st_r <= st_nxt;
	end

	assign err = st_r.err;
endmodule : dlps_inmon

// [logic/dlps_sel.sv]
// format and test-pattern selection with APB register access
`timescale 1ns/100ps
`include "dlps_regs.svh"
module dlps_sel
	import dlps_pkg::*;
(
	input  wire logic        pclk,        // system clock, 125 MHz
	input  wire logic        presetn,     // async reset, active low
	input  wire logic        ce,          // clock enable, freezes state
	input  wire logic        psel,        // apb select
	input  wire logic        penable,     // apb access phase
	input  wire logic        pwrite,      // apb write
	input  wire logic [11:0] paddr,       // apb byte address
	input  wire logic [31:0] pwdata,      // apb write data
	output logic      [31:0] prdata,      // apb read data
	output logic             pready,      // apb ready
	output logic             pslverr,     // apb error, unmapped address
	input  wire logic        in_present,  // serial_video_input carrier
	input  wire logic [3:0]  in_fmt,      // serial_video_input format
	output dlps_sel_type     sel,         // active selection
	output logic             resync,      // framing resync pulse
	output logic             irq          // level interrupt
);
	typedef struct packed {
		dlps_menu_type       menu;
		dlps_fmt_type        cand;
		dlps_sel_type        sel;
		logic [3:0]          samp_req;
		logic                resync;
		logic [`DLPS_IRQ_W-1:0] ist;
		logic [`DLPS_IRQ_W-1:0] ien;
		logic [31:0]         rdata;
		logic                err_d;
	} dlps_st_type;

	dlps_st_type st_r, st_nxt;
	logic        in_err;
	logic        acc, wr, rd;
	dlps_cmd_type cmd;

	// ************************************************************************
	// helpers
	// ************************************************************************

	// patterns held by each set
	function automatic logic [3:0] set_size(input dlps_set_type s);
		unique case (s)
			SET_BARS:  set_size = `DLPS_N_BARS;
			SET_LIN:   set_size = `DLPS_N_LIN;
			SET_FLAT:  set_size = `DLPS_N_FLAT;
			SET_MON:   set_size = `DLPS_N_MON;
			SET_PULSE: set_size = `DLPS_N_PULSE;
			default:   set_size = `DLPS_N_PULSE;
		endcase
	endfunction : set_size

	// step a value forward or back, wrapping within n entries
	function automatic logic [3:0] step(input logic [3:0] v,
		input logic [3:0] n, input logic up);
		if (up)
			step = (v + 4'h1 >= n) ? 4'h0 : v + 4'h1;
		else
			step = (v == 4'h0) ? n - 4'h1 : v - 4'h1;
	endfunction : step

	// fractional rates need the 1.001-divided clock
	function automatic logic is_frac(input dlps_fmt_type f);
		is_frac = (f == FMT_2398SF) | (f == FMT_2398P) | (f == FMT_2997P) |
			(f == FMT_5994I) | (f == FMT_5994P);
	endfunction : is_frac

	// the three high-rate progressive formats
	function automatic logic is_hrp(input dlps_fmt_type f);
		is_hrp = (f == FMT_50P) | (f == FMT_5994P) | (f == FMT_60P);
	endfunction : is_hrp

	// ************************************************************************
	// converter input monitor
	// ************************************************************************
	dlps_inmon u_inmon (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.present (in_present),
		.in_fmt  (in_fmt),
		.conv    (st_r.sel.conv),
		.fmt     (st_r.sel.fmt),
		.err     (in_err)
	);

	// apb decode: zero-wait slave, answers in the first access cycle
	assign acc = psel & penable & ce;
	assign wr  = acc & pwrite;
	assign rd  = psel & ~penable & ~pwrite;
	assign cmd = dlps_cmd_type'(pwdata[`DLPS_CMD_CODE_MSB:`DLPS_CMD_CODE_LSB]);

	// ************************************************************************
	// next state
	// ************************************************************************
	always_comb begin
		logic       cmd_wr;
		logic [3:0] n;
		logic       ev_fmt;
		logic       ev_clk;
		st_nxt = st_r;
		cmd_wr = wr & (paddr == `DLPS_CMD_OFS);
		n      = set_size(st_r.sel.pset);
		ev_fmt = 1'b0;
		ev_clk = 1'b0;
		st_nxt.resync = 1'b0;

		// menu commands arrive as writes of a code to the command register
		if (cmd_wr) begin
			unique case (cmd)
				CMD_FORMAT: begin
					st_nxt.menu = MENU_FMT;
					st_nxt.cand = st_r.sel.fmt;
				end
				CMD_LEFT, CMD_RIGHT: begin
					unique case (st_r.menu)
						MENU_FMT: st_nxt.cand = dlps_fmt_type'(step(st_r.cand,
							`DLPS_N_FMT, cmd == CMD_RIGHT));
						MENU_SIG: st_nxt.sel.pat = step(st_r.sel.pat, n,
							cmd == CMD_RIGHT);
						MENU_CONV: st_nxt.sel.y2gbr = ~st_r.sel.y2gbr;
						default: st_nxt.menu = st_r.menu;
					endcase
				end
				CMD_ENTER: begin
					// only a confirmed candidate becomes the output format
					if (st_r.menu == MENU_FMT) begin
						st_nxt.sel.fmt = st_r.cand;
						st_nxt.menu    = MENU_MAIN;
						ev_fmt = (st_r.cand != st_r.sel.fmt);
						// no prompt: the clock simply follows the format
						ev_clk = is_frac(st_r.cand) != st_r.sel.clk_frac;
						st_nxt.sel.clk_frac = is_frac(st_r.cand);
					end
				end
				CMD_CANCEL: st_nxt.menu = MENU_MAIN;
				CMD_BARS, CMD_LIN, CMD_FLAT, CMD_MON, CMD_PULSE: begin
					dlps_set_type s;
					s = dlps_set_type'(3'(cmd - CMD_BARS));
					st_nxt.menu     = MENU_SIG;
					st_nxt.sel.conv = 1'b0;
					// only a press while this set's menu is open counts as a repeat
					if (st_r.menu == MENU_SIG && !st_r.sel.conv &&
						st_r.sel.pset == s)
						st_nxt.sel.pat = step(st_r.sel.pat, n, 1'b1);
					else begin
						st_nxt.sel.pset = s;
						st_nxt.sel.pat  = 4'h0;
					end
				end
				CMD_OTHER: begin
					st_nxt.menu = MENU_CONV;
					if (st_r.sel.conv)
						st_nxt.sel.y2gbr = ~st_r.sel.y2gbr;
					st_nxt.sel.conv = 1'b1;
				end
				default: st_nxt.menu = st_r.menu;
			endcase
		end

		// sampling structure request, honoured unless overridden
		if (wr && paddr == `DLPS_SAMP_OFS)
			st_nxt.samp_req = pwdata[`DLPS_SAMP_W-1:0];
		st_nxt.sel.samp = is_hrp(st_nxt.sel.fmt) ?
			`DLPS_SAMP_422_10 : st_nxt.samp_req;
		if (wr && paddr == `DLPS_IRQ_EN_OFS)
			st_nxt.ien = pwdata[`DLPS_IRQ_W-1:0];

		st_nxt.resync = ev_fmt;
		st_nxt.err_d  = in_err;

		// sticky events: set beats a clear in the same cycle
		if (wr && paddr == `DLPS_IRQ_CLR_OFS)
			st_nxt.ist = st_r.ist & ~pwdata[`DLPS_IRQ_W-1:0];
		st_nxt.ist[`DLPS_IRQ_FMT_BIT] = st_nxt.ist[`DLPS_IRQ_FMT_BIT] | ev_fmt;
		st_nxt.ist[`DLPS_IRQ_CLK_BIT] = st_nxt.ist[`DLPS_IRQ_CLK_BIT] | ev_clk;
		st_nxt.ist[`DLPS_IRQ_ERR_BIT] = st_nxt.ist[`DLPS_IRQ_ERR_BIT] |
			(in_err & ~st_r.err_d);

		// read data captured in setup so it is registered in access
		if (rd) begin
			unique case (paddr)
				`DLPS_CAND_OFS:     st_nxt.rdata = {28'h0, st_r.cand};
				`DLPS_STAT_OFS: begin
					st_nxt.rdata = 32'h0;
					st_nxt.rdata[`DLPS_ST_FMT_MSB:`DLPS_ST_FMT_LSB] = st_r.sel.fmt;
					st_nxt.rdata[`DLPS_ST_SET_MSB:`DLPS_ST_SET_LSB] = st_r.sel.pset;
					st_nxt.rdata[`DLPS_ST_PAT_MSB:`DLPS_ST_PAT_LSB] = st_r.sel.pat;
					st_nxt.rdata[`DLPS_ST_CONV_BIT] = st_r.sel.conv;
					st_nxt.rdata[`DLPS_ST_FRAC_BIT] = st_r.sel.clk_frac;
					st_nxt.rdata[`DLPS_ST_ERR_BIT]  = in_err;
					st_nxt.rdata[`DLPS_ST_SAMP_MSB:`DLPS_ST_SAMP_LSB] = st_r.sel.samp;
				end
				`DLPS_IRQ_STAT_OFS: st_nxt.rdata = {29'h0, st_r.ist};
				`DLPS_IRQ_EN_OFS:   st_nxt.rdata = {29'h0, st_r.ien};
				`DLPS_SAMP_OFS:     st_nxt.rdata = {28'h0, st_r.samp_req};
				default:            st_nxt.rdata = 32'h0;
			endcase
		end
	end

	// ************************************************************************
	// state register
	// ************************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r              <= '0;
			st_r.cand         <= dlps_fmt_type'(`DLPS_FMT_RST);
			st_r.sel.fmt      <= dlps_fmt_type'(`DLPS_FMT_RST);
			st_r.sel.clk_frac <= 1'b1;
			st_r.sel.samp     <= `DLPS_SAMP_RST;
			st_r.samp_req     <= `DLPS_SAMP_RST;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	// unmapped addresses answer with pslverr; command is write-only
	function automatic logic mapped(input logic [11:0] a);
		mapped = (a == `DLPS_CMD_OFS) | (a == `DLPS_CAND_OFS) |
			(a == `DLPS_STAT_OFS) | (a == `DLPS_IRQ_STAT_OFS) |
			(a == `DLPS_IRQ_CLR_OFS) | (a == `DLPS_IRQ_EN_OFS) |
			(a == `DLPS_SAMP_OFS);
	endfunction : mapped

	assign pready  = ce;
	assign pslverr = psel & penable & ~mapped(paddr);
	assign prdata  = st_r.rdata;
	assign sel     = st_r.sel;
	assign resync  = st_r.resync;
	assign irq     = |(st_r.ist & st_r.ien);
endmodule : dlps_sel

// [tb/dlps_src.sv]
// behavioural serial video source feeding the selector's input pins
`timescale 1ns/100ps
module dlps_src
	import dlps_pkg::*;
(
	input  wire logic  pclk,        // system clock
	input  wire logic  on,          // source connected
	input  dlps_fmt_type fmt,       // format the source sends
	output logic       in_present,  // carrier present
	output logic [3:0] in_fmt       // detected format code
);
	initial begin
		in_present = 1'b0;
		in_fmt = 4'h0;
	end
	// a dead link carries no stable code, so it toggles every cycle
	always @(posedge pclk) begin
		in_present <= on;
		in_fmt <= on ? fmt : ~in_fmt;
	end
endmodule : dlps_src

// [tb/dlps_sel_checker.sv]
// assertion checker for the format and pattern selector
`timescale 1ns/100ps
module dlps_sel_checker
	import dlps_pkg::*;
(
	input wire logic  pclk,     // system clock
	input wire logic  presetn,  // async reset, active low
	input wire logic  ce,       // clock enable
	input wire logic  psel,     // apb select
	input wire logic  penable,  // apb access phase
	input wire logic  pwrite,   // apb write
	input dlps_sel_type sel,    // active selection
	input wire logic  resync    // framing resync pulse
);
	logic       frac_w;
	logic [3:0] nmax;
	// fractional formats and set sizes, worked out independently
	assign frac_w = sel.fmt inside {4'h0, 4'h2, 4'h5, 4'h8, 4'hb};
	assign nmax = (sel.pset == SET_FLAT) ? 4'hb : (sel.pset == SET_MON) ?
		4'h7 : (sel.pset == SET_PULSE) ? 4'h1 : 4'h3;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_fmt_legal: assert property (sel.fmt <= FMT_60P)
		else $error("format code out of range");
	a_fmt_on_write: assert property ($changed(sel.fmt) |->
		$past(psel && penable && pwrite && ce)) else $error("format moved");
	a_resync_follow: assert property ($changed(sel.fmt) |-> ##[0:1] resync)
		else $error("no resync on format change");
	a_resync_once: assert property (resync |=> !resync)
		else $error("resync longer than one cycle");
	a_samp_forced: assert property (sel.fmt >= FMT_50P && $stable(sel.fmt)
		|-> sel.samp == 4'h7) else $error("no 422 override");
	a_clk_rate: assert property ($stable(sel.fmt) |-> sel.clk_frac == frac_w)
		else $error("clock rate wrong");
	a_clk_no_prompt: assert property ($changed(sel.clk_frac) |->
		$changed(sel.fmt)) else $error("clock moved alone");
	a_pat_range: assert property (sel.pat < nmax)
		else $error("pattern outside set");
	c_resync: cover property (resync);
	c_conv: cover property (sel.conv);
	c_flat_top: cover property (sel.pset == SET_FLAT && sel.pat == 4'ha);
endmodule : dlps_sel_checker
bind dlps_sel dlps_sel_checker u_chk (.pclk(pclk), .presetn(presetn),
	.ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .sel(sel),
	.resync(resync));

// [tb/tb.sv]
// self-checking bench for the format and pattern selector
`timescale 1ns/100ps
`include "dlps_regs.svh"
module tb;
	import dlps_pkg::*;
	logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, irq;
	logic resync, in_present, src_on, slv;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, sv;
	logic [3:0]  in_fmt;
	dlps_sel_type sel;
	dlps_fmt_type src_fmt;
	int errors, n_checks, n_rs, k, f, s;
	logic [3:0] nset [5] = '{4'h3, 4'h3, 4'hb, 4'h7, 4'h1};
	dlps_sel DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.in_present(in_present), .in_fmt(in_fmt), .sel(sel),
		.resync(resync), .irq(irq));
	dlps_src u_src (.pclk(pclk), .on(src_on), .fmt(src_fmt),
		.in_present(in_present), .in_fmt(in_fmt));
	// ********
	// bus and compare tasks
	// ********
	task automatic summarize;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : summarize
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// the request holds until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (k == 50) begin
			errors++;
			summarize();
		end
		rd = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic cmd(input logic [3:0] c);
		apb(1'b1, `DLPS_CMD_OFS, {28'h0, c});
	endtask : cmd
	task automatic rdc(input logic [11:0] a, input logic [31:0] m,
		input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd & m, e);
	endtask : rdc
	function automatic logic [31:0] fst(input logic [3:0] f);
		return {12'h0, (f >= 4'ha) ? 4'h7 : 4'h3, 2'b0,
			f inside {4'h0, 4'h2, 4'h5, 4'h8, 4'hb}, 9'h0, f};
	endfunction : fst
	// ********
	// scenarios
	// ********
	task automatic s_reset;
		rdc(`DLPS_STAT_OFS, 32'hffffffff, 32'h2008);
		rdc(`DLPS_CMD_OFS, 32'hffffffff, 32'h0);
		apb(1'b1, 12'h01c, 32'h4);
		chk({31'h0, slv}, 32'h1);
		rdc(`DLPS_CAND_OFS, 32'hf, 32'h8);
	endtask : s_reset
	task automatic s_confirm;
		cmd(CMD_FORMAT);
		cmd(CMD_RIGHT);
		cmd(CMD_RIGHT);
		rdc(`DLPS_STAT_OFS, 32'hf, 32'h8);
		rdc(`DLPS_CAND_OFS, 32'hf, 32'ha);
		cmd(CMD_ENTER);
		apb(1'b1, `DLPS_SAMP_OFS, 32'h3);
		rdc(`DLPS_STAT_OFS, 32'hf200f, 32'h7000a);
		chk(n_rs, 1);
		rdc(`DLPS_IRQ_STAT_OFS, 32'h7, 32'h3);
		@(negedge pclk);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, `DLPS_IRQ_EN_OFS, 32'h3);
		// irq follows the registered enable, so look once it has settled
		@(negedge pclk);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, `DLPS_IRQ_CLR_OFS, 32'h3);
		@(negedge pclk);
		chk({31'h0, irq}, 32'h0);
		rdc(`DLPS_SAMP_OFS, 32'hf, 32'h3);
	endtask : s_confirm
	task automatic s_formats;
		for (f = 0; f < 13; f++) begin
			cmd(CMD_FORMAT);
			cmd(CMD_RIGHT);
			cmd(CMD_ENTER);
			rdc(`DLPS_STAT_OFS, 32'hf200f, fst(4'((f + 11) % 13)));
			chk(n_rs, f + 2);
		end
		cmd(CMD_FORMAT);
		cmd(CMD_LEFT);
		cmd(CMD_CANCEL);
		cmd(CMD_FORMAT);
		cmd(CMD_ENTER);
		rdc(`DLPS_STAT_OFS, 32'hf200f, fst(4'ha));
		chk(n_rs, 14);
	endtask : s_formats
	task automatic s_patterns;
		for (s = 0; s < 5; s++) begin
			cmd(4'(6 + s));
			rdc(`DLPS_STAT_OFS, 32'h1f70, 32'(s) << 4);
			cmd(CMD_RIGHT);
			rdc(`DLPS_STAT_OFS, 32'hf00, (32'h1 % nset[s]) << 8);
			for (f = 1; f < nset[s]; f++) cmd(4'(6 + s));
			rdc(`DLPS_STAT_OFS, 32'hf00, 32'h0);
		end
	endtask : s_patterns
	task automatic s_unassigned;
		apb(1'b0, `DLPS_STAT_OFS, 32'h0);
		sv = rd;
		for (s = 12; s < 17; s++) begin
			cmd(4'(s));
			rdc(`DLPS_STAT_OFS, 32'hffffffff, sv);
		end
	endtask : s_unassigned
	task automatic s_conv;
		cmd(CMD_OTHER);
		repeat (6) @(posedge pclk);
		rdc(`DLPS_STAT_OFS, 32'h5000, 32'h5000);
		rdc(`DLPS_IRQ_STAT_OFS, 32'h4, 32'h4);
		cmd(CMD_RIGHT);
		@(negedge pclk);
		chk({31'h0, sel.y2gbr}, 32'h1);
		cmd(CMD_OTHER);
		@(negedge pclk);
		chk({31'h0, sel.y2gbr}, 32'h0);
		src_on <= 1'b1;
		src_fmt <= FMT_50I;
		repeat (6) @(posedge pclk);
		rdc(`DLPS_STAT_OFS, 32'h5000, 32'h1000);
		src_fmt <= FMT_60I;
		repeat (6) @(posedge pclk);
		rdc(`DLPS_STAT_OFS, 32'h5000, 32'h5000);
		cmd(CMD_BARS);
		rdc(`DLPS_STAT_OFS, 32'h1000, 32'h0);
	endtask : s_conv
	// ********
	// clock, reset and main sequence
	// ********
	always @(posedge pclk) if (resync === 1'b1) n_rs <= n_rs + 1;
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	initial begin
		{presetn, psel, penable, pwrite, src_on} = 5'h0;
		ce = 1'b1;
		paddr = 12'h0;
		pwdata = 32'h0;
		src_fmt = FMT_50I;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		s_reset();
		s_confirm();
		s_formats();
		s_patterns();
		s_unassigned();
		s_conv();
		summarize();
	end
endmodule : tb
